// >>> hw/ldfc_top.sv
// led driver function control: serial capture, latches, power save, register slave
//
// How it works
// - status select 00 or 11: latch strobe copies no status into shift register.
// - status select 01: latch strobe loads open-circuit flags into shift register.
// - status select 10: latch strobe loads short-circuit flags into shift register.
// - open threshold 000..100 give levels 0..4; 101..111 give level 1.
// - short threshold 00 half, 01 seventy percent, 10 and 11 ninety percent.
// - power-save select 00: never sleep, whatever the on/off latch holds.
// - select 01: sleep on all-zero latch, wake on next shift-clock rising edge.
// - switching to 01 while asleep keeps sleeping until a later shift-clock edge.
// - select 10: sleep on all-zero latch, wake when non-zero data is latched.
// - switching to 10 while asleep keeps sleeping until non-zero data is latched.
// - power-save select resets to 11, power save enabled in every condition.
// - on/off latch changes only at the strobe ending an on/off write.
// - control fields change only on strobe with top bit set and key 96h.
// - control fields sit at bits 25:24, 28:26, 30:29 and 32:31.
// - blank high forces outputs off; low lets latched-on channels sink while awake.
`timescale 1ns/1ns
`include "ldfc_regs.svh"
module ldfc_top
  import ldfc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // serial link pins from the display controller
  input wire logic sclk_in,
  input wire logic serial_data_in,
  input wire logic latch_strobe_in,
  input wire logic blank_in,
  // per-channel detector flags
  input wire logic [`LDFC_CH_N-1:0] open_circuit_detect_in,
  input wire logic [`LDFC_CH_N-1:0] short_circuit_detect_in,
  // link and channel outputs
  output logic serial_data_out,
  output logic [`LDFC_CH_N-1:0] sink_output_channel_out,
  output logic [2:0] open_threshold_level_out,
  output logic [1:0] short_threshold_level_out,
  output logic power_save_state_out,
  // avalon-mm register slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // interrupt
  output logic irq_out
);
  localparam int SYNC_W = 4 + 2 * `LDFC_CH_N;

  logic [SYNC_W-1:0] sync_bus;
  logic sclk_s;
  logic sin_s;
  logic latch_s;
  logic blank_s;
  logic [`LDFC_CH_N-1:0] open_s;
  logic [`LDFC_CH_N-1:0] short_s;

  ldfc_sync2 #(.WIDTH(SYNC_W)) u_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in({sclk_in, serial_data_in, latch_strobe_in, blank_in,
               open_circuit_detect_in, short_circuit_detect_in}),
    .sync_out(sync_bus)
  );

  assign {sclk_s, sin_s, latch_s, blank_s, open_s, short_s} = sync_bus;

  // edge finding on the synchronised link clock and strobe
  logic sclk_d;
  logic latch_d;
  logic sclk_rise;
  logic latch_rise;
  assign sclk_rise = sclk_s && !sclk_d;
  assign latch_rise = latch_s && !latch_d;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sclk_d <= 1'b0;
      latch_d <= 1'b0;
    end
    else
    begin
      sclk_d <= sclk_s;
      latch_d <= latch_s;
    end
  end

  // shift register, on/off latch and control fields
  logic [`LDFC_SHIFT_W-1:0] shreg;
  logic [`LDFC_SHIFT_W-1:0] next_shreg;
  logic [`LDFC_CH_N-1:0] onoff;
  logic [`LDFC_CH_N-1:0] next_onoff;
  ldfc_mode_t status_load_select;
  ldfc_mode_t next_status_load_select;
  logic [2:0] open_threshold_select;
  logic [2:0] next_open_threshold_select;
  ldfc_mode_t short_threshold_select;
  ldfc_mode_t next_short_threshold_select;
  ldfc_mode_t power_save_select;
  ldfc_mode_t next_power_save_select;
  logic onoff_write;
  logic config_write;
  logic onoff_zero;

  // top bit low means on/off data; top bit high plus key means control data
  assign onoff_write = latch_rise && !shreg[`LDFC_SHIFT_MSB];
  assign config_write = latch_rise && shreg[`LDFC_SHIFT_MSB] &&
    (shreg[`LDFC_CMD_MSB:`LDFC_CMD_LSB] == `LDFC_WRITE_KEY);
  assign onoff_zero = (shreg[`LDFC_CH_N-1:0] == '0);

  always_comb
  begin
    next_shreg = shreg;
    next_onoff = onoff;
    next_status_load_select = status_load_select;
    next_open_threshold_select = open_threshold_select;
    next_short_threshold_select = short_threshold_select;
    next_power_save_select = power_save_select;
    // a strobe wins over a coincident shift edge
    if (onoff_write)
    begin
      next_onoff = shreg[`LDFC_CH_N-1:0];
      unique case (status_load_select)
        `LDFC_SL_OPEN: next_shreg = {1'b0, open_s};
        `LDFC_SL_SHORT: next_shreg = {1'b0, short_s};
        default: next_shreg = shreg;
      endcase
    end
    else if (config_write)
    begin
      next_status_load_select = shreg[`LDFC_SL_MSB:`LDFC_SL_LSB];
      next_open_threshold_select = shreg[`LDFC_OT_MSB:`LDFC_OT_LSB];
      next_short_threshold_select = shreg[`LDFC_ST_MSB:`LDFC_ST_LSB];
      next_power_save_select = shreg[`LDFC_PS_MSB:`LDFC_PS_LSB];
    end
    else if (sclk_rise && !latch_rise)
    begin
      next_shreg = {shreg[`LDFC_SHIFT_W-2:0], sin_s};
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      shreg <= '0;
      onoff <= '0;
      status_load_select <= `LDFC_SL_RESET;
      open_threshold_select <= `LDFC_OT_RESET;
      short_threshold_select <= `LDFC_ST_RESET;
      power_save_select <= `LDFC_PS_RESET;
    end
    else
    begin
      shreg <= next_shreg;
      onoff <= next_onoff;
      status_load_select <= next_status_load_select;
      open_threshold_select <= next_open_threshold_select;
      short_threshold_select <= next_short_threshold_select;
      power_save_select <= next_power_save_select;
    end
  end

  assign serial_data_out = shreg[`LDFC_SHIFT_MSB];

  // power-save state machine
  ldfc_ps_t power_save_state;
  ldfc_ps_t next_power_save_state;
  logic wake_event;
  logic sleep_event;

  always_comb
  begin
    next_power_save_state = power_save_state;
    unique case (power_save_state)
      ps_awake:
        if (onoff_write && onoff_zero && power_save_select != `LDFC_PS_NEVER)
          next_power_save_state = ps_asleep;
      ps_asleep:
        if (power_save_select == `LDFC_PS_NEVER)
          next_power_save_state = ps_awake;
        else if (onoff_write && !onoff_zero &&
                 (power_save_select == `LDFC_PS_LATCH ||
                  power_save_select == `LDFC_PS_ALWAYS))
          next_power_save_state = ps_awake;
        // the strobe that changes mode never doubles as the waking edge
        else if (sclk_rise && !latch_rise &&
                 (power_save_select == `LDFC_PS_CLOCK ||
                  power_save_select == `LDFC_PS_ALWAYS))
          next_power_save_state = ps_awake;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      power_save_state <= ps_awake;
    else
      power_save_state <= next_power_save_state;
  end

  assign sleep_event = (power_save_state == ps_awake) && (next_power_save_state == ps_asleep);
  assign wake_event = (power_save_state == ps_asleep) && (next_power_save_state == ps_awake);

  // registered outputs: sinks, decoded thresholds, sleep flag
  logic [`LDFC_CH_N-1:0] next_sink;
  logic [2:0] next_open_level;
  logic [1:0] next_short_level;

  always_comb
  begin
    // sleep overrides blank so a stray low blank cannot draw current
    if (power_save_state == ps_asleep || blank_s)
      next_sink = '0;
    else
      next_sink = onoff;
    if (open_threshold_select <= 3'h4)
      next_open_level = open_threshold_select;
    else
      next_open_level = 3'h1;
    if (short_threshold_select[1])
      next_short_level = 2'h2;
    else
      next_short_level = short_threshold_select;
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sink_output_channel_out <= '0;
      open_threshold_level_out <= 3'h0;
      short_threshold_level_out <= 2'h0;
      power_save_state_out <= 1'b0;
    end
    else
    begin
      sink_output_channel_out <= next_sink;
      open_threshold_level_out <= next_open_level;
      short_threshold_level_out <= next_short_level;
      power_save_state_out <= (next_power_save_state == ps_asleep);
    end
  end

  // register slave with one wait state; interrupt status and mask
  logic [`LDFC_STAT_W-1:0] irq_status;
  logic [`LDFC_STAT_W-1:0] next_irq_status;
  logic [`LDFC_STAT_W-1:0] irq_mask;
  logic [`LDFC_STAT_W-1:0] next_irq_mask;
  logic [`LDFC_STAT_W-1:0] events;
  logic [`LDFC_STAT_W-1:0] clear_bits;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic bus_commit;

  assign bus_commit = !avs_waitrequest_out;

  always_comb
  begin
    events = '0;
    events[`LDFC_STAT_SLEEP] = sleep_event;
    events[`LDFC_STAT_WAKE] = wake_event;
    events[`LDFC_STAT_CONFIG] = config_write;
    events[`LDFC_STAT_LATCH] = onoff_write;
    clear_bits = '0;
    next_irq_mask = irq_mask;
    if (bus_commit && avs_write_in && avs_byteenable_in[0])
    begin
      if (avs_address_in == `LDFC_OFF_STATUS)
        clear_bits = avs_writedata_in[`LDFC_STAT_W-1:0];
      if (avs_address_in == `LDFC_OFF_MASK)
        next_irq_mask = avs_writedata_in[`LDFC_STAT_W-1:0];
    end
    // a new event beats a clear in the same cycle
    next_irq_status = (irq_status & ~clear_bits) | events;
    next_waitrequest = !((avs_read_in || avs_write_in) && avs_waitrequest_out);
    next_readdata = avs_readdata_out;
    if (avs_read_in && avs_waitrequest_out)
    begin
      unique case (avs_address_in)
        `LDFC_OFF_STATUS: next_readdata = {28'h0, irq_status};
        `LDFC_OFF_MASK: next_readdata = {28'h0, irq_mask};
        `LDFC_OFF_CONTROL: next_readdata = {22'h0, power_save_state == ps_asleep,
          power_save_select, short_threshold_select, open_threshold_select,
          status_load_select};
        default: next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irq_status <= '0;
      irq_mask <= '0;
      irq_out <= 1'b0;
      avs_readdata_out <= 32'h0;
      avs_waitrequest_out <= 1'b1;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq_out <= |(next_irq_status & next_irq_mask);
      avs_readdata_out <= next_readdata;
      avs_waitrequest_out <= next_waitrequest;
    end
  end

  // checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_STATUS_NONE: assert property (
    onoff_write && (status_load_select == 2'h0 || status_load_select == 2'h3)
    |=> shreg == $past(shreg))
    else $error("status loaded although select says none");
  AST_STATUS_OPEN: assert property (
    onoff_write && status_load_select == 2'h1
    |=> shreg[47:0] == $past(open_s) && !shreg[48])
    else $error("open flags not loaded on strobe");
  AST_STATUS_SHORT: assert property (
    onoff_write && status_load_select == 2'h2 |=> shreg[47:0] == $past(short_s))
    else $error("short flags not loaded on strobe");
  AST_OPEN_DECODE: assert property (
    open_threshold_select > 3'h4 |=> open_threshold_level_out == 3'h1)
    else $error("open threshold alias decoded wrongly");
  AST_SHORT_DECODE: assert property (
    short_threshold_select == 2'h3 ##1 short_threshold_select == 2'h3
    |-> short_threshold_level_out == 2'h2)
    else $error("short threshold 11 not ninety percent");
  AST_NEVER_SLEEP: assert property (
    power_save_select == 2'h0 |=> !power_save_state_out)
    else $error("sleeping with power save disabled");
  AST_CLOCK_WAKE: assert property (
    power_save_state == ps_asleep && power_save_select == 2'h1 && sclk_rise && !latch_rise
    |=> power_save_state == ps_awake ##1 !power_save_state_out)
    else $error("shift edge did not wake in clock mode");
  AST_STAY_ON_SWITCH: assert property (
    power_save_state == ps_asleep && config_write && shreg[32:31] == 2'h1
    |=> power_save_state == ps_asleep)
    else $error("woke on the mode-change strobe");
  AST_LATCH_WAKE: assert property (
    power_save_state == ps_asleep && power_save_select == 2'h2 && onoff_write
    |=> (power_save_state == ps_awake) == !$past(onoff_zero))
    else $error("latch wake mismatch");
  AST_SLEEP_ENTRY: assert property (
    power_save_state == ps_awake && onoff_write && onoff_zero && power_save_select != 2'h0
    |=> power_save_state_out && power_save_state == ps_asleep)
    else $error("all-zero latch did not sleep");
  AST_ONOFF_HOLD: assert property (
    !onoff_write |=> $stable(onoff))
    else $error("on/off latch moved without strobe");
  AST_CONFIG_KEY: assert property (
    !config_write |=> $stable(power_save_select) && $stable(open_threshold_select))
    else $error("control fields moved without keyed strobe");
  AST_BLANK_OFF: assert property (
    blank_s |=> sink_output_channel_out == '0)
    else $error("sink active while blank high");
  AST_SLEEP_OFF: assert property (
    power_save_state == ps_asleep [*2] |-> sink_output_channel_out == '0)
    else $error("sink active while asleep");
endmodule : ldfc_top

// >>> hw/ldfc_regs.svh
// constants for the led function-control block: offsets, fields, resets, codes
`ifndef LDFC_REGS_SVH
`define LDFC_REGS_SVH

`define LDFC_SHIFT_W 49
`define LDFC_CH_N 48
`define LDFC_SHIFT_MSB 48
`define LDFC_CMD_MSB 47
`define LDFC_CMD_LSB 40
`define LDFC_WRITE_KEY 8'h96

`define LDFC_SL_MSB 25
`define LDFC_SL_LSB 24
`define LDFC_OT_MSB 28
`define LDFC_OT_LSB 26
`define LDFC_ST_MSB 30
`define LDFC_ST_LSB 29
`define LDFC_PS_MSB 32
`define LDFC_PS_LSB 31

`define LDFC_SL_RESET 2'h0
`define LDFC_OT_RESET 3'h0
`define LDFC_ST_RESET 2'h0
`define LDFC_PS_RESET 2'h3

`define LDFC_SL_OPEN 2'h1
`define LDFC_SL_SHORT 2'h2
`define LDFC_PS_NEVER 2'h0
`define LDFC_PS_CLOCK 2'h1
`define LDFC_PS_LATCH 2'h2
`define LDFC_PS_ALWAYS 2'h3

`define LDFC_OFF_STATUS 4'h0
`define LDFC_OFF_MASK 4'h4
`define LDFC_OFF_CONTROL 4'h8

`define LDFC_STAT_W 4
`define LDFC_STAT_SLEEP 0
`define LDFC_STAT_WAKE 1
`define LDFC_STAT_CONFIG 2
`define LDFC_STAT_LATCH 3

`endif

// >>> hw/ldfc_pkg.sv
// types shared by the led function-control block
package ldfc_pkg;
  typedef enum logic {ps_awake, ps_asleep} ldfc_ps_t;
  typedef logic [1:0] ldfc_mode_t;
endpackage : ldfc_pkg

// >>> hw/ldfc_sync2.sv
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ns
module ldfc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // first stage feeds only the second stage
  always_comb
  begin
    next_meta = async_in;
    next_sync = meta;
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= next_meta;
      sync_out <= next_sync;
    end
  end
endmodule : ldfc_sync2

// >>> dv/ldfc_ctrl_model.sv
// display controller model: shift clock, serial data, latch strobe and blank
`timescale 1ns/1ns
module ldfc_ctrl_model #(
  parameter int WAKE_SETUP_CLK = 6
) (
  // clock
  input wire logic clock_in,
  // pins towards the driver
  output logic sclk_out,
  output logic serial_data_out,
  output logic latch_strobe_out,
  output logic blank_out,
  // serial data back from the driver
  input wire logic serial_data_in
);
  logic blank_user;

  initial
  begin
    sclk_out = 1'b0;
    serial_data_out = 1'b0;
    latch_strobe_out = 1'b0;
    blank_out = 1'b1;
    blank_user = 1'b1;
  end

  task set_blank(input logic v);
    blank_user = v;
    blank_out <= v;
    @(posedge clock_in);
  endtask : set_blank

  // one shift clock period is eight clocks; between frames the clock moves only for a wake pulse
  task tick(output logic b);
    repeat (4) @(posedge clock_in);
    b = serial_data_in;
    sclk_out <= 1'b1;
    repeat (4) @(posedge clock_in);
    sclk_out <= 1'b0;
  endtask : tick

  // blank held high across a wake-up so the sinks settle before lighting
  task hold_blank();
    blank_out <= 1'b1;
    repeat (WAKE_SETUP_CLK) @(posedge clock_in);
    blank_out <= blank_user;
  endtask : hold_blank

  task frame(input logic [48:0] w, input logic strobe, output logic [48:0] rx);
    int i;
    logic b;
    rx = '0;
    for (i = 48; i >= 0; i--)
    begin
      serial_data_out <= w[i];
      tick(b);
      rx = {rx[47:0], b};
    end
    // released line toggles so a stale bit never looks valid
    serial_data_out <= ~w[0];
    if (strobe)
    begin
      repeat (4) @(posedge clock_in);
      latch_strobe_out <= 1'b1;
      hold_blank();
      latch_strobe_out <= 1'b0;
      repeat (4) @(posedge clock_in);
    end
  endtask : frame

  task wake_pulse();
    logic b;
    blank_out <= 1'b1;
    tick(b);
    hold_blank();
  endtask : wake_pulse
endmodule : ldfc_ctrl_model

// >>> dv/ldfc_top_tb.sv
// self-checking bench for the led function-control block
`timescale 1ns/1ns
`include "ldfc_regs.svh"
module ldfc_top_tb;
  localparam logic [47:0] OPEN_PAT = 48'h0F0F_1234_5678;
  localparam logic [47:0] SHORT_PAT = 48'h8001_00FF_0C30;
  localparam logic [47:0] ONOFF_PAT = 48'h5A5A_C3C3_9669;
  localparam int LIMIT = 40000;
  logic clock_in, rst_n_in, sclk, sdi, lat, blank, sdo, wreq, irq, ps_state;
  logic [47:0] sinks;
  logic [2:0] ot_lvl;
  logic [1:0] st_lvl;
  logic [3:0] addr;
  logic [3:0] be;
  logic rd, wr;
  logic [31:0] wdata, rdata, d;
  logic [48:0] rx;
  logic [47:0] st_exp;
  int errors, n_checks, cycles, i;

  ldfc_top ldfc_top_inst (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .serial_data_in(sdi),
    .latch_strobe_in(lat), .blank_in(blank), .open_circuit_detect_in(OPEN_PAT),
    .short_circuit_detect_in(SHORT_PAT), .serial_data_out(sdo),
    .sink_output_channel_out(sinks), .open_threshold_level_out(ot_lvl),
    .short_threshold_level_out(st_lvl), .power_save_state_out(ps_state),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .irq_out(irq));

  ldfc_ctrl_model ldfc_ctrl_model_inst (
    .clock_in(clock_in), .sclk_out(sclk), .serial_data_out(sdi),
    .latch_strobe_out(lat), .blank_out(blank), .serial_data_in(sdo));

  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  task close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // hang guard: a wait that never ends counts as a mismatch
  always @(posedge clock_in)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      errors++;
      close_out();
    end
  end

  task chk(input string nm, input logic [48:0] e, input logic [48:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // request held until waitrequest is sampled low, then one idle edge
  task av_wr(input logic [3:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    do @(posedge clock_in); while (wreq !== 1'b0);
    wr <= 1'b0;
    @(posedge clock_in);
  endtask : av_wr

  task av_rd(input logic [3:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    do @(posedge clock_in); while (wreq !== 1'b0);
    v = rdata;
    rd <= 1'b0;
    @(posedge clock_in);
  endtask : av_rd

  // latch effects reach the sinks nine clocks after the strobe pin rises, once the blank held high by the model drops
  task send(input logic [48:0] w);
    ldfc_ctrl_model_inst.frame(w, 1'b1, rx);
    repeat (8) @(posedge clock_in);
  endtask : send

  task cfg(input logic [1:0] sl, input logic [2:0] ot, input logic [1:0] st,
           input logic [1:0] ps);
    send({1'b1, `LDFC_WRITE_KEY, 7'h00, ps, st, ot, sl, 24'h000000});
  endtask : cfg

  task wake();
    ldfc_ctrl_model_inst.wake_pulse();
    repeat (8) @(posedge clock_in);
  endtask : wake

  function automatic logic [2:0] olvl(input logic [2:0] x);
    return (x > 3'h4) ? 3'h1 : x;
  endfunction : olvl

  initial
  begin
    rst_n_in = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    be = 4'hF;
    errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    av_rd(4'h8, d);
    chk("control at reset", 32'h180, d);
    av_rd(4'hC, d);
    chk("unmapped read", 32'h0, d);
    send(49'h0);
    chk("sleep default mode", 1'b1, ps_state);
    chk("sinks asleep", 48'h0, sinks);
    cfg(2'h0, 3'h0, 2'h0, 2'h0);
    send(49'h0);
    chk("never sleep", 1'b0, ps_state);
    ldfc_ctrl_model_inst.set_blank(1'b0);
    send({1'b0, ONOFF_PAT});
    chk("sinks on", ONOFF_PAT, sinks);
    ldfc_ctrl_model_inst.frame({1'b0, ~ONOFF_PAT}, 1'b0, rx);
    chk("sinks while shifting", ONOFF_PAT, sinks);
    ldfc_ctrl_model_inst.set_blank(1'b1);
    repeat (6) @(posedge clock_in);
    chk("sinks blanked", 48'h0, sinks);
    ldfc_ctrl_model_inst.set_blank(1'b0);
    for (i = 0; i < 8; i++)
    begin
      cfg(2'h0, i[2:0], i[1:0], 2'h0);
      chk("open level", olvl(i[2:0]), ot_lvl);
      chk("short level", (i[1:0] == 2'h3) ? 2'h2 : i[1:0], st_lvl);
      av_rd(4'h8, d);
      chk("control fields", {i[1:0], i[2:0], 2'h0}, d);
    end
    send({1'b1, 8'h95, 7'h00, 2'h0, 2'h0, 3'h4, 2'h0, 24'h0});
    chk("wrong key ignored", 3'h1, ot_lvl);
    for (i = 0; i < 4; i++)
    begin
      cfg(i[1:0], 3'h0, 2'h0, 2'h0);
      send({1'b0, ONOFF_PAT});
      send({1'b0, ONOFF_PAT});
      st_exp = (i == 1) ? OPEN_PAT : (i == 2) ? SHORT_PAT : ONOFF_PAT;
      chk("status data", st_exp, rx[47:0]);
    end
    cfg(2'h0, 3'h0, 2'h0, 2'h1);
    send(49'h0);
    chk("sleep clock mode", 1'b1, ps_state);
    chk("blank ignored asleep", 48'h0, sinks);
    wake();
    chk("woken by shift clock", 1'b0, ps_state);
    cfg(2'h0, 3'h0, 2'h0, 2'h2);
    send(49'h0);
    chk("sleep latch mode", 1'b1, ps_state);
    send(49'h3);
    chk("woken by latch", 1'b0, ps_state);
    chk("sinks after wake", 48'h3, sinks);
    send(49'h0);
    cfg(2'h0, 3'h0, 2'h0, 2'h1);
    chk("asleep after switch", 1'b1, ps_state);
    wake();
    chk("woken after switch", 1'b0, ps_state);
    av_wr(4'h0, 32'hF);
    av_wr(4'h4, 32'h0);
    cfg(2'h0, 3'h0, 2'h0, 2'h0);
    chk("irq masked", 1'b0, irq);
    av_wr(4'h4, 32'h4);
    repeat (2) @(posedge clock_in);
    chk("irq raised", 1'b1, irq);
    // lane 0 disabled: the mask write must be ignored
    be <= 4'hE;
    av_wr(4'h4, 32'h0);
    be <= 4'hF;
    av_rd(4'h4, d);
    chk("mask readback", 32'h4, d);
    av_rd(4'h0, d);
    chk("status control bit", 1'b1, d[2]);
    av_wr(4'h0, 32'h4);
    repeat (2) @(posedge clock_in);
    chk("irq cleared", 1'b0, irq);
    close_out();
  end
endmodule : ldfc_top_tb
